// [core/cps_consts.svh]
// constants of the instruction sequencer and return stack
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH
`define CPS_PC_W 11
`define CPS_PC_RESET 11'h000
`define CPS_PC_STEP 11'h001
`define CPS_STACK_DEPTH 6
`define CPS_PHASE_COUNT 4
`define CPS_OFF_PCL 12'h000
`define CPS_OFF_STATUS 12'h004
`define CPS_OFF_SEQSTAT 12'h008
`define CPS_FLAG_C 0
`define CPS_FLAG_AC 1
`define CPS_FLAG_Z 2
`define CPS_FLAG_OV 3
`define CPS_STATUS_RESET 4'h0
`define CPS_STAT_INTPEND 5
`define CPS_STAT_DUMMY 6
`define CPS_STAT_PCLPEND 7
`define CPS_STAT_PHASE 8
`endif

// [core/cps_pkg.sv]
// types shared by the sequencer and the alu
package cps_pkg;
	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cps_phase_t;
	typedef enum logic [2:0] {OP_NONE, OP_JUMP, OP_CALL, OP_SKZ, OP_SKNZ, OP_RET, OP_INTERRUPT_RETURN} cps_seq_op_t;
	typedef enum logic [3:0] {
		ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
		ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC
	} cps_alu_op_t;
endpackage : cps_pkg

// [core/cps_alu.sv]
// eight-bit alu with status flag update
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_alu (
	input cps_pkg::cps_alu_op_t aluOp,
	input logic [7:0] opA,
	input logic [7:0] opB,
	input logic [3:0] flagsIn,
	output logic [7:0] result,
	output logic [3:0] flagsOut
);
	import cps_pkg::*;
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] addB;
	logic [7:0] adj;
	logic ci;
	logic cin;

	always_comb begin
		cin = flagsIn[`CPS_FLAG_C];
		sum = 9'h000;
		half = 5'h00;
		addB = 8'h00;
		adj = 8'h00;
		ci = 1'b0;
		result = opA;
		flagsOut = flagsIn;
		case (aluOp)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				// subtract is add of the complement; carry set means no borrow
				addB = (aluOp == ALU_SUB || aluOp == ALU_SBC) ? ~opB : opB;
				ci = (aluOp == ALU_ADD) ? 1'b0 : ((aluOp == ALU_SUB) ? 1'b1 : cin);
				sum = {1'b0, opA} + {1'b0, addB} + {8'h00, ci};
				half = {1'b0, opA[3:0]} + {1'b0, addB[3:0]} + {4'h0, ci};
				result = sum[7:0];
				flagsOut[`CPS_FLAG_C] = sum[8];
				flagsOut[`CPS_FLAG_AC] = half[4];
				flagsOut[`CPS_FLAG_OV] = (opA[7] == addB[7]) && (sum[7] != opA[7]);
			end
			ALU_DAA: begin
				adj = {(opA[7:4] > 4'h9 || cin) ? 4'h6 : 4'h0,
					(opA[3:0] > 4'h9 || flagsIn[`CPS_FLAG_AC]) ? 4'h6 : 4'h0};
				sum = {1'b0, opA} + {1'b0, adj};
				result = sum[7:0];
				flagsOut[`CPS_FLAG_C] = sum[8] | cin;
			end
			ALU_AND: result = opA & opB;
			ALU_OR: result = opA | opB;
			ALU_XOR: result = opA ^ opB;
			ALU_CPL: result = ~opA;
			ALU_RR: result = {opA[0], opA[7:1]};
			ALU_RRC: begin
				result = {cin, opA[7:1]};
				flagsOut[`CPS_FLAG_C] = opA[0];
			end
			ALU_RL: result = {opA[6:0], opA[7]};
			ALU_RLC: begin
				result = {opA[6:0], cin};
				flagsOut[`CPS_FLAG_C] = opA[7];
			end
			ALU_INC: result = opA + 8'h01;
			ALU_DEC: result = opA - 8'h01;
			default: result = opA;
		endcase
		// rotates leave the zero flag alone
		if (aluOp != ALU_RR && aluOp != ALU_RRC && aluOp != ALU_RL && aluOp != ALU_RLC) begin
			flagsOut[`CPS_FLAG_Z] = (result == 8'h00);
		end
	end
endmodule : cps_alu

// [core/cps_seq_top.sv]
// instruction sequencer: phases, program counter, return stack, apb registers
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_seq_top #(
	parameter int STACK_DEPTH = `CPS_STACK_DEPTH
) (
	input logic sys_clk,
	input logic rst_n,
	input logic [11:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [3:0] phaseClk,
	output logic [10:0] pmemAddr,
	output logic pmemFetch,
	output logic dummyCycle,
	input cps_pkg::cps_seq_op_t seqOp,
	input logic [10:0] seqTarget,
	input cps_pkg::cps_alu_op_t aluOp,
	input logic [7:0] aluA,
	input logic [7:0] aluB,
	output logic [7:0] aluResult,
	output logic [3:0] statusFlags,
	output logic aluValid,
	input logic intReq,
	input logic [10:0] intVector,
	output logic intAck
);
	import cps_pkg::*;

	// ==========================================================
	// parameter check
	if (STACK_DEPTH < 2 || STACK_DEPTH > 8) begin : g_bad_depth
		$error("stack depth must lie in 2..8");
	end

	// ==========================================================
	// state
	typedef struct packed {
		cps_phase_t phase;
		logic [3:0] phaseClk;
		logic [`CPS_PC_W-1:0] pc;
		logic [`CPS_PC_W-1:0] memAddr;
		logic fetch;
		logic dummy;
		logic [STACK_DEPTH-1:0][`CPS_PC_W-1:0] stack;
		logic [2:0] top;
		logic [3:0] count;
		logic intPend;
		logic intAck;
		logic pclPend;
		logic [7:0] pclVal;
		logic [3:0] flags;
		logic [7:0] aluRes;
		logic aluValid;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cps_state_t;

	// first cycle after reset executes nothing while address zero is fetched
	localparam cps_state_t RST_S = '{
		phase: PH_T1,
		phaseClk: 4'h1,
		pc: `CPS_PC_RESET,
		memAddr: `CPS_PC_RESET,
		fetch: 1'b1,
		dummy: 1'b1,
		top: 3'(STACK_DEPTH - 1),
		flags: `CPS_STATUS_RESET,
		default: '0
	};

	cps_state_t s_r;
	cps_state_t s_nxt;
	logic [7:0] aluOut;
	logic [3:0] aluFlags;
	logic [`CPS_PC_W-1:0] tgt;
	logic doPush;
	logic doPop;
	logic [`CPS_PC_W-1:0] pushVal;
	logic stackFull;
	logic [`CPS_PC_W-1:0] topVal;
	logic [2:0] pcPage;
	logic execNow;

	function automatic logic [2:0] idxInc(input logic [2:0] i);
		idxInc = (i == 3'(STACK_DEPTH - 1)) ? 3'h0 : i + 3'h1;
	endfunction : idxInc

	function automatic logic [2:0] idxDec(input logic [2:0] i);
		idxDec = (i == 3'h0) ? 3'(STACK_DEPTH - 1) : i - 3'h1;
	endfunction : idxDec

	function automatic logic [3:0] phaseHot(input cps_phase_t p);
		phaseHot = 4'h1 << p;
	endfunction : phaseHot

	assign stackFull = (s_r.count == 4'(STACK_DEPTH));
	assign topVal = s_r.stack[s_r.top];
	assign pcPage = s_r.pc[10:8];
	assign execNow = (s_r.phase == PH_T4) && !s_r.dummy;

	// ==========================================================
	// alu
	cps_alu u_alu (
		.aluOp(aluOp),
		.opA(aluA),
		.opB(aluB),
		.flagsIn(s_r.flags),
		.result(aluOut),
		.flagsOut(aluFlags)
	);

	// ==========================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.fetch = 1'b0;
		s_nxt.intAck = 1'b0;
		s_nxt.aluValid = 1'b0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		tgt = s_r.pc + `CPS_PC_STEP;
		doPush = 1'b0;
		doPop = 1'b0;
		pushVal = s_r.pc;
		case (s_r.phase)
			PH_T1: s_nxt.phase = PH_T2;
			PH_T2: s_nxt.phase = PH_T3;
			PH_T3: s_nxt.phase = PH_T4;
			PH_T4: begin
				s_nxt.phase = PH_T1;
				s_nxt.dummy = 1'b0;
				// executes the word fetched last cycle while this cycle's word waits
				if (!s_r.dummy) begin
					s_nxt.aluRes = aluOut;
					s_nxt.flags = aluFlags;
					s_nxt.aluValid = 1'b1;
					case (seqOp)
						OP_JUMP: begin
							tgt = seqTarget;
							s_nxt.dummy = 1'b1;
						end
						OP_CALL: begin
							doPush = 1'b1;
							tgt = seqTarget;
							s_nxt.dummy = 1'b1;
						end
						OP_SKZ: s_nxt.dummy = aluFlags[`CPS_FLAG_Z];
						OP_SKNZ: s_nxt.dummy = !aluFlags[`CPS_FLAG_Z];
						OP_RET, OP_INTERRUPT_RETURN: begin
							doPop = 1'b1;
							tgt = topVal;
							s_nxt.dummy = 1'b1;
						end
						default: s_nxt.dummy = 1'b0;
					endcase
					if (seqOp == OP_NONE && s_r.pclPend) begin
						tgt = {s_r.pc[10:8], s_r.pclVal};
						s_nxt.dummy = 1'b1;
						s_nxt.pclPend = 1'b0;
					end else if (seqOp == OP_NONE && s_r.intPend && !stackFull) begin
						// held back while full so the interrupt push cannot overflow the stack
						doPush = 1'b1;
						tgt = intVector;
						s_nxt.dummy = 1'b1;
						s_nxt.intAck = 1'b1;
						s_nxt.intPend = 1'b0;
					end
				end
				s_nxt.pc = tgt;
				s_nxt.memAddr = tgt;
				s_nxt.fetch = 1'b1;
			end
			default: s_nxt.phase = PH_T1;
		endcase
		s_nxt.phaseClk = phaseHot(s_nxt.phase);

		// stack as a ring: overflow silently overwrites the oldest slot
		if (doPush) begin
			s_nxt.top = idxInc(s_r.top);
			s_nxt.stack[idxInc(s_r.top)] = pushVal;
			if (!stackFull) begin
				s_nxt.count = s_r.count + 4'h1;
			end
		end else if (doPop && s_r.count != 4'h0) begin
			s_nxt.top = idxDec(s_r.top);
			s_nxt.count = s_r.count - 4'h1;
		end

		// apb: data is prepared in setup, ready shows in the first access cycle
		if (psel && !penable) begin
			s_nxt.pready = 1'b1;
			case (paddr)
				`CPS_OFF_PCL: s_nxt.prdata = {24'h000000, s_r.pc[7:0]};
				`CPS_OFF_STATUS: s_nxt.prdata = {28'h0000000, s_r.flags};
				`CPS_OFF_SEQSTAT: begin
					s_nxt.prdata = 32'h00000000;
					s_nxt.prdata[`CPS_STAT_INTPEND] = s_r.intPend;
					s_nxt.prdata[`CPS_STAT_DUMMY] = s_r.dummy;
					s_nxt.prdata[`CPS_STAT_PCLPEND] = s_r.pclPend;
					s_nxt.prdata[`CPS_STAT_PHASE +: 2] = s_r.phase;
				end
				default: begin
					s_nxt.prdata = 32'h00000000;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
			case (paddr)
				`CPS_OFF_PCL: begin
					s_nxt.pclPend = 1'b1;
					s_nxt.pclVal = pwdata[7:0];
				end
				`CPS_OFF_STATUS: s_nxt.flags = pwdata[3:0];
				default: s_nxt.flags = s_nxt.flags;
			endcase
		end

		// a request arriving while the pending one is taken is kept
		if (intReq) begin
			s_nxt.intPend = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= RST_S;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign phaseClk = s_r.phaseClk;
	assign pmemAddr = s_r.memAddr;
	assign pmemFetch = s_r.fetch;
	assign dummyCycle = s_r.dummy;
	assign aluResult = s_r.aluRes;
	assign statusFlags = s_r.flags;
	assign aluValid = s_r.aluValid;
	assign intAck = s_r.intAck;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence phaseRun;
		s_r.phase == PH_T1 ##1 s_r.phase == PH_T2 ##1 s_r.phase == PH_T3 ##1 s_r.phase == PH_T4;
	endsequence

	sequence idleCycle;
		s_r.dummy [*4] ##1 !s_r.dummy;
	endsequence

	sequence plainStep;
		execNow && seqOp == OP_NONE && !s_r.pclPend && !(s_r.intPend && !stackFull);
	endsequence

	phase_order_a: assert property (s_r.phase == PH_T4 |=> phaseRun)
		else $error("phases out of order");

	phase_onehot_a: assert property ($onehot(phaseClk) && phaseClk == phaseHot(s_r.phase))
		else $error("phase clocks overlap");

	seq_step_a: assert property (plainStep |=> pmemFetch && pmemAddr == $past(s_r.pc) + `CPS_PC_STEP)
		else $error("sequential step wrong");

	fetch_t1_a: assert property (pmemFetch |-> phaseClk == 4'h1 ##1 !pmemFetch [*3])
		else $error("fetch outside phase one");

	jump_target_a: assert property (execNow && seqOp == OP_JUMP |=> pmemAddr == $past(seqTarget))
		else $error("jump target not loaded");

	branch_idle_a: assert property (execNow && seqOp inside {OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN} |=> idleCycle)
		else $error("branch missed its extra cycle");

	skip_idle_a: assert property (execNow && seqOp == OP_SKZ && aluFlags[`CPS_FLAG_Z]
		|=> s_r.dummy && pmemAddr == $past(s_r.pc) + `CPS_PC_STEP)
		else $error("taken skip did not idle");

	skip_nz_a: assert property (execNow && seqOp == OP_SKNZ && !aluFlags[`CPS_FLAG_Z]
		|=> s_r.dummy && pmemAddr == $past(s_r.pc) + `CPS_PC_STEP)
		else $error("taken nonzero skip did not idle");

	alu_valid_a: assert property (execNow |=> aluValid && aluResult == $past(aluOut) && phaseClk == 4'h1)
		else $error("alu result not delivered");

	// a low byte write landing on the consuming edge stays pending: set wins
	pcl_page_a: assert property (execNow && seqOp == OP_NONE && s_r.pclPend
		|=> s_r.dummy && pmemAddr == {$past(pcPage), $past(s_r.pclVal)}
			&& (!s_r.pclPend || $past(psel && penable && pwrite && paddr == `CPS_OFF_PCL)))
		else $error("low byte jump wrong");

	call_push_a: assert property (execNow && seqOp == OP_CALL && !stackFull
		|=> s_r.count == $past(s_r.count) + 4'h1 && topVal == $past(s_r.pc))
		else $error("call did not push");

	int_take_a: assert property (execNow && seqOp == OP_NONE && !s_r.pclPend
		&& s_r.intPend && !stackFull
		|=> intAck && pmemAddr == $past(intVector) && s_r.count == $past(s_r.count) + 4'h1)
		else $error("interrupt not taken");

	ret_pop_a: assert property (execNow && seqOp == OP_RET && s_r.count != 4'h0
		|=> pmemAddr == $past(topVal))
		else $error("return address wrong");

	interrupt_return_pop_a: assert property (execNow && seqOp == OP_INTERRUPT_RETURN && s_r.count != 4'h0
		|=> pmemAddr == $past(topVal) && s_r.dummy)
		else $error("interrupt return address wrong");

	int_held_a: assert property (execNow && seqOp == OP_NONE && !s_r.pclPend
		&& s_r.intPend && stackFull
		|=> !intAck && s_r.intPend)
		else $error("interrupt taken on full stack");

	overflow_a: assert property (execNow && seqOp == OP_CALL && stackFull
		|=> stackFull && topVal == $past(s_r.pc) && pmemAddr == $past(seqTarget))
		else $error("call on full stack failed");
endmodule : cps_seq_top

// [verif/cps_prog_mem.sv]
// program memory model that hands decoded words to the sequencer
`timescale 1ns/1ps
module cps_prog_mem (
	input logic sys_clk,
	input logic rst_n,
	input logic [3:0] phaseClk,
	input logic [10:0] pmemAddr,
	input logic pmemFetch,
	output cps_pkg::cps_seq_op_t seqOp,
	output logic [10:0] seqTarget,
	output cps_pkg::cps_alu_op_t aluOp,
	output logic [7:0] aluA,
	output logic [7:0] aluB
);
	import cps_pkg::*;
	cps_seq_op_t opMem [2048];
	logic [10:0] tgtMem [2048];
	cps_alu_op_t aluMem [2048];
	logic [7:0] aMem [2048];
	logic [7:0] bMem [2048];
	logic [10:0] fetchAddr_r;
	logic [10:0] execAddr_r;
	// ==========
	// contents
	task automatic wipe();
		for (int i = 0; i < 2048; i++) begin
			opMem[i] = OP_NONE;
			tgtMem[i] = 11'h000;
			aluMem[i] = ALU_PASS;
			aMem[i] = 8'h00;
			bMem[i] = 8'h00;
		end
	endtask : wipe
	task automatic put(input logic [10:0] a, input cps_seq_op_t op, input logic [10:0] t,
			input cps_alu_op_t ao = ALU_PASS, input logic [7:0] x = 8'h00, input logic [7:0] y = 8'h00);
		opMem[a] = op;
		tgtMem[a] = t;
		aluMem[a] = ao;
		aMem[a] = x;
		bMem[a] = y;
	endtask : put
	initial begin
		wipe();
	end
	// ==========
	// pipeline: word fetched now is decoded during the next cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetchAddr_r <= 11'h000;
			execAddr_r <= 11'h000;
		end else if (pmemFetch) begin
			execAddr_r <= fetchAddr_r;
			fetchAddr_r <= pmemAddr;
		end
	end
	// outside T4 a live branch is shown, so a sequencer that samples early misbehaves
	assign seqOp = phaseClk[3] ? opMem[execAddr_r] : OP_CALL;
	assign seqTarget = phaseClk[3] ? tgtMem[execAddr_r] : ~tgtMem[execAddr_r];
	assign aluOp = phaseClk[3] ? aluMem[execAddr_r] : ALU_DEC;
	assign aluA = aMem[execAddr_r];
	assign aluB = bMem[execAddr_r];
endmodule : cps_prog_mem

// [verif/cpu_sequencer_pc_stack_tb.sv]
// self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`include "cps_consts.svh"
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
	$display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module cpu_sequencer_pc_stack_tb;
	import cps_pkg::*;
	// ==========
	// signals
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic intReq = 1'b0;
	logic [10:0] intVector = 11'h400;
	logic [31:0] prdata;
	logic pready, pslverr, pmemFetch, dummyCycle, aluValid, intAck;
	logic [3:0] phaseClk, statusFlags;
	logic [10:0] pmemAddr, seqTarget;
	logic [7:0] aluResult, aluA, aluB;
	cps_seq_op_t seqOp;
	cps_alu_op_t aluOp;
	int errTotal = 0;
	int testsRun = 0;
	always #5 sys_clk = ~sys_clk;
	cps_seq_top dut (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.phaseClk, .pmemAddr, .pmemFetch, .dummyCycle, .seqOp, .seqTarget, .aluOp, .aluA, .aluB, .aluResult,
		.statusFlags, .aluValid, .intReq, .intVector, .intAck);
	cps_prog_mem pm (.sys_clk, .rst_n, .phaseClk, .pmemAddr, .pmemFetch, .seqOp, .seqTarget, .aluOp, .aluA, .aluB);
	// ==========
	// helpers
	task automatic wrapUp();
		$display("mismatches %0d, checks %0d", errTotal, testsRun);
		if (errTotal == 0 && testsRun > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrapUp
	task automatic timeout();
		errTotal++;
		$display("wrong value at %0t: wait ran out", $time);
		wrapUp();
	endtask : timeout
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	// each scenario starts from a fresh reset held for 20 clocks, with the program memory wiped
	task automatic doReset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		pm.wipe();
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
	endtask : doReset
	task automatic waitFetch(input logic [10:0] a);
		int n;
		n = 0;
		while (!(pmemFetch === 1'b1 && pmemAddr === a)) begin
			tick(1);
			n++;
			if (n > 400) timeout();
		end
	endtask : waitFetch
	task automatic seqChk(input logic [10:0] a, input logic d);
		tick(4);
		`CHK(pmemAddr, a)
		`CHK(dummyCycle, d)
	endtask : seqChk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		int n;
		logic rdy;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		// answer is read at the very edge that closes the access, before it updates
		do begin
			@(posedge sys_clk);
			rdy = pready;
			rd = prdata;
			er = pslverr;
			n++;
			if (n > 50) timeout();
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// ==========
	// scenarios
	task automatic tPhases();
		doReset();
		`CHK(pmemAddr, 11'h000)
		for (int n = 0; n < 12; n++) begin
			`CHK(phaseClk, 4'h1 << (n % 4))
			`CHK(pmemAddr, 11'(n / 4))
			`CHK(pmemFetch, n % 4 == 0)
			tick(1);
		end
	endtask : tPhases
	task automatic tJump();
		doReset();
		pm.put(11'h010, OP_JUMP, 11'h7FE);
		waitFetch(11'h011);
		seqChk(11'h7FE, 1'b1);
		seqChk(11'h7FF, 1'b0);
		seqChk(11'h000, 1'b0);
	endtask : tJump
	task automatic tCall();
		doReset();
		pm.put(11'h005, OP_CALL, 11'h200);
		pm.put(11'h200, OP_RET, 11'h000);
		waitFetch(11'h006);
		seqChk(11'h200, 1'b1);
		seqChk(11'h201, 1'b0);
		seqChk(11'h006, 1'b1);
	endtask : tCall
	task automatic tStackFull();
		logic [10:0] lastA;
		int n;
		doReset();
		for (int i = 0; i < 6; i++) begin
			pm.put(i == 0 ? 11'h003 : 11'(12'h0F1 + 12'(i) * 12'h010), OP_CALL, 11'(12'h100 + 12'(i) * 12'h010));
		end
		// seventh call on a full stack overwrites the oldest entry
		pm.put(11'h153, OP_CALL, 11'h155);
		pm.put(11'h155, OP_RET, 11'h000);
		pm.put(11'h400, OP_INTERRUPT_RETURN, 11'h000);
		waitFetch(11'h152);
		@(posedge sys_clk);
		intReq <= 1'b1;
		@(posedge sys_clk);
		intReq <= 1'b0;
		lastA = 11'h000;
		for (n = 0; n < 200 && intAck !== 1'b1; n++) begin
			if (pmemFetch === 1'b1) lastA = pmemAddr;
			tick(1);
		end
		if (intAck !== 1'b1) timeout();
		`CHK(lastA, 11'h155)
		`CHK(pmemAddr, 11'h400)
		seqChk(11'h401, 1'b0);
		seqChk(11'h155, 1'b1);
	endtask : tStackFull
	task automatic tApb();
		logic [31:0] rd;
		logic er;
		doReset();
		apb(1'b0, `CPS_OFF_STATUS, 32'h0, rd, er);
		`CHK(rd, 32'h0)
		apb(1'b0, 12'h00C, 32'h0, rd, er);
		`CHK(er, 1'b1)
		`CHK(rd, 32'h0)
		pm.put(11'h002, OP_JUMP, 11'h305);
		waitFetch(11'h307);
		apb(1'b1, `CPS_OFF_PCL, 32'h40, rd, er);
		`CHK(er, 1'b0)
		waitFetch(11'h340);
		`CHK(dummyCycle, 1'b1)
		seqChk(11'h341, 1'b0);
		apb(1'b0, `CPS_OFF_PCL, 32'h0, rd, er);
		`CHK(rd[31:8], 24'h0)
		`CHK(rd[7:0], 8'h41)
	endtask : tApb
	task automatic tAlu();
		cps_alu_op_t ops [10] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL, ALU_INC, ALU_DEC,
			ALU_RL, ALU_ADD};
		logic [7:0] want [10] = '{8'h4B, 8'h2D, 8'h0C, 8'h3F, 8'h33, 8'hC3, 8'h3D, 8'h3B, 8'h78, 8'h10};
		doReset();
		for (int i = 0; i < 10; i++) begin
			pm.put(11'(i + 1), OP_NONE, 11'h000, ops[i], i == 9 ? 8'hF0 : 8'h3C,
				i == 9 ? 8'h20 : (i < 5 ? 8'h0F : 8'h3C));
		end
		pm.put(11'h00B, OP_SKZ, 11'h000, ALU_XOR, 8'h55, 8'h55);
		pm.put(11'h00E, OP_SKNZ, 11'h000, ALU_INC, 8'h00, 8'h00);
		for (int i = 0; i < 10; i++) begin
			waitFetch(11'(i + 3));
			`CHK(aluValid, 1'b1)
			`CHK(aluResult, want[i])
		end
		`CHK(statusFlags[`CPS_FLAG_C], 1'b1)
		waitFetch(11'h00D);
		`CHK(dummyCycle, 1'b1)
		`CHK(statusFlags[`CPS_FLAG_Z], 1'b1)
		waitFetch(11'h00F);
		`CHK(dummyCycle, 1'b0)
		waitFetch(11'h010);
		`CHK(dummyCycle, 1'b1)
		`CHK(aluResult, 8'h01)
		`CHK(statusFlags[`CPS_FLAG_Z], 1'b0)
	endtask : tAlu
	// ==========
	// main sequence
	initial begin
		tPhases();
		tJump();
		tCall();
		tStackFull();
		tApb();
		tAlu();
		wrapUp();
	end
endmodule : cpu_sequencer_pc_stack_tb
